// ==== bench/mvad_host_wires.sv ====
`timescale 1ns/1ps
// Host side of the open-drain fault and ready lines, pulled high when no one drives them.
module mvad_host_wires (
    input wire logic fault_out_i,
    input wire logic fault_oe_i,
    input wire logic ready_out_i,
    input wire logic ready_oe_i,
    output logic fault_line_n_o,
    output logic ready_line_n_o
);
    // Wired levels resolved from the enables; a released line floats to the pull-up.
    assign fault_line_n_o = fault_oe_i ? fault_out_i : 1'h1;
    assign ready_line_n_o = ready_oe_i ? ready_out_i : 1'h1;
endmodule : mvad_host_wires

// ==== bench/mvad_monitor.sv ====
`timescale 1ns/1ps
// Checks field split, answer timing and permission answers at the decoder ports.
module mvad_monitor (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic [1:0] PAGE_SIZE_SEL_I,
    input wire logic VIRTUAL_ADDRESS_FLAG_I,
    input wire logic [31:0] VADDR_I,
    input wire logic [1:0] ACCESS_KIND_I,
    input wire logic [1:0] EXECUTION_MODE_LINES_I,
    input wire logic [7:0] SEGMENT_PERM_I,
    input wire logic [1:0] SECTION_ID_FIELD_O,
    input wire logic [12:0] SEGMENT_SELECT_FIELD_O,
    input wire logic [5:0] PAGE_SELECT_FIELD_O,
    input wire logic [12:0] PAGE_BYTE_OFFSET_FIELD_O,
    input wire logic DECODE_VALID_O,
    input wire logic TRANSLATION_FAULT_OE_O,
    input wire logic SYNC_READY_OE_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    logic [1:0] lvl_perm;
    logic allow;
    // Permission pair of the current level and whether the requested kind may pass.
    assign lvl_perm = SEGMENT_PERM_I[7 - 2 * EXECUTION_MODE_LINES_I -: 2];
    assign allow = (ACCESS_KIND_I == 2'h3) ? (lvl_perm == 2'h3) : (ACCESS_KIND_I != 2'h0) ? lvl_perm[1] : (lvl_perm != 2'h0);
    sequence req_s; $rose(VIRTUAL_ADDRESS_FLAG_I); endsequence
    sequence ans_s; ##4 DECODE_VALID_O ##1 !DECODE_VALID_O; endsequence
    answer_timing_a: assert property (req_s |-> ans_s) else $error("answer pulse late or long");
    section_field_a: assert property (DECODE_VALID_O |-> SECTION_ID_FIELD_O == VADDR_I[31:30]) else $error("bad section");
    segment_field_a: assert property (DECODE_VALID_O |-> SEGMENT_SELECT_FIELD_O == VADDR_I[29:17]) else $error("bad segment");
    page_8k_a: assert property (DECODE_VALID_O && PAGE_SIZE_SEL_I[1]
        |-> {PAGE_SELECT_FIELD_O, PAGE_BYTE_OFFSET_FIELD_O} == {2'h0, VADDR_I[16:0]}) else $error("bad 8K split");
    page_2k_a: assert property (DECODE_VALID_O && PAGE_SIZE_SEL_I == 2'h0
        |-> {PAGE_SELECT_FIELD_O, PAGE_BYTE_OFFSET_FIELD_O} == {VADDR_I[16:11], 2'h0, VADDR_I[10:0]}) else $error("bad 2K");
    page_4k_a: assert property (DECODE_VALID_O && PAGE_SIZE_SEL_I == 2'h1
        |-> {PAGE_SELECT_FIELD_O, PAGE_BYTE_OFFSET_FIELD_O} == {1'h0, VADDR_I[16:12], 1'h0, VADDR_I[11:0]}) else $error("bad 4K");
    perm_answer_a: assert property (DECODE_VALID_O |-> TRANSLATION_FAULT_OE_O == !allow && SYNC_READY_OE_O == allow)
        else $error("wrong permission answer");
    line_release_a: assert property ($fell(VIRTUAL_ADDRESS_FLAG_I) |-> ##[1:4] !(TRANSLATION_FAULT_OE_O || SYNC_READY_OE_O))
        else $error("lines held");
endmodule : mvad_monitor
bind mvad_decode mvad_monitor u_mon (.*);

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
// Random accesses; each expectation is queued and matched on the next valid pulse.
module tb_top;
    logic clk = 1'h0, rst = 1'h1, flag = 1'h0, vld, f_out, f_oe, r_out, r_oe, f_n, r_n;
    logic [1:0] sel = 2'h0, acc = 2'h0, lvl = 2'h0, section_id_field;
    logic [7:0] perm = 8'h0;
    logic [31:0] addr = 32'h0;
    logic [12:0] seg, ofs;
    logic [5:0] pg;
    logic [35:0] exp_q[$];
    int error_cnt = 0, total_checks = 0, seed = 3313;
    always #2 clk = ~clk;
    mvad_decode u_dut (.MCLK_I(clk), .RST_I(rst), .PAGE_SIZE_SEL_I(sel), .VIRTUAL_ADDRESS_FLAG_I(flag), .VADDR_I(addr),
        .ACCESS_KIND_I(acc), .EXECUTION_MODE_LINES_I(lvl), .SEGMENT_PERM_I(perm), .SECTION_ID_FIELD_O(section_id_field),
        .SEGMENT_SELECT_FIELD_O(seg), .PAGE_SELECT_FIELD_O(pg), .PAGE_BYTE_OFFSET_FIELD_O(ofs), .DECODE_VALID_O(vld),
        .TRANSLATION_FAULT_OUT_O(f_out), .TRANSLATION_FAULT_OE_O(f_oe), .SYNC_READY_OUT_O(r_out), .SYNC_READY_OE_O(r_oe));
    mvad_host_wires u_host (.fault_out_i(f_out), .fault_oe_i(f_oe), .ready_out_i(r_out), .ready_oe_i(r_oe),
        .fault_line_n_o(f_n), .ready_line_n_o(r_n));
    task check(input logic [35:0] seen, input logic [35:0] expv);
        total_checks++;
        if (seen !== expv) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : check
    task give_verdict;
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // One access with random fields; the flag stands eight cycles, then rests six.
    task do_access;
        logic [31:0] r;
        logic [18:0] po;
        logic [1:0] p;
        logic ok;
        addr = $random(seed);
        r = $random(seed);
        {sel, acc, lvl, perm} = r[13:0];
        p = perm[7 - 2 * lvl -: 2];
        ok = (acc == 2'h3) ? (p == 2'h3) : (acc != 2'h0) ? p[1] : (p != 2'h0);
        case (sel)
            2'h0: po = {addr[16:11], 2'h0, addr[10:0]};
            2'h1: po = {1'h0, addr[16:12], 1'h0, addr[11:0]};
            default: po = {2'h0, addr[16:0]};
        endcase
        exp_q.push_back({addr[31:17], po, !ok, ok});
        flag = 1'h1;
        repeat (8) @(negedge clk);
        flag = 1'h0;
        repeat (6) @(negedge clk);
    endtask : do_access
    // Each valid pulse, with the wired lines, is compared with the oldest expectation; a pulse with none is a fault.
    always @(negedge clk) begin
        if (vld === 1'h1) begin
            if (exp_q.size() == 0) check(36'h1, 36'h0);
            else check({section_id_field, seg, pg, ofs, ~f_n, ~r_n}, exp_q.pop_front());
        end
    end
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'h0;
        repeat (3) @(negedge clk);
        repeat (30) do_access();
        // Mid-run reset: the four fields and both output enables must return to zero, then decoding resumes.
        rst = 1'h1;
        repeat (2) @(negedge clk);
        check({section_id_field, seg, pg, ofs, f_oe, r_oe}, 36'h0);
        rst = 1'h0;
        repeat (3) @(negedge clk);
        repeat (30) do_access();
        check(36'(exp_q.size()), 36'h0);
        give_verdict();
    end
    // Watchdog well beyond the expected run length.
    initial begin
        #8000;
        error_cnt++;
        give_verdict();
    end
endmodule : tb_top

// ==== hdl/mvad_decode.sv ====
`timescale 1ns/1ps
// Virtual address decoder and segment access checker.
module mvad_decode (
    input wire logic MCLK_I,
    input wire logic RST_I,
    input wire logic [1:0] PAGE_SIZE_SEL_I,
    input wire logic VIRTUAL_ADDRESS_FLAG_I,
    input wire logic [31:0] VADDR_I,
    input wire logic [1:0] ACCESS_KIND_I,
    input wire logic [1:0] EXECUTION_MODE_LINES_I,
    input wire logic [7:0] SEGMENT_PERM_I,
    output logic [1:0] SECTION_ID_FIELD_O,
    output logic [12:0] SEGMENT_SELECT_FIELD_O,
    output logic [5:0] PAGE_SELECT_FIELD_O,
    output logic [12:0] PAGE_BYTE_OFFSET_FIELD_O,
    output logic DECODE_VALID_O,
    output logic TRANSLATION_FAULT_OUT_O,
    output logic TRANSLATION_FAULT_OE_O,
    output logic SYNC_READY_OUT_O,
    output logic SYNC_READY_OE_O
);
    logic [1:0] pgsz_s1;
    logic [1:0] pgsz_s2;
    logic [1:0] pgsz;
    logic vad_s1;
    logic vad_s2;
    logic vad_q;
    logic [31:0] vaddr_s1;
    logic [31:0] vaddr_s2;
    logic [1:0] acc_s1;
    logic [1:0] acc_s2;
    logic [1:0] lvl_s1;
    logic [1:0] lvl_s2;
    logic [7:0] perm_s1;
    logic [7:0] perm_s2;
    logic allow;
    mvad_pkg::mvad_state_t state;
    mvad_pkg::mvad_state_t next_state;

    // Byte offset width for a page size code.
    function automatic logic [3:0] ofs_width(input logic [1:0] sel);
        case (sel)
            mvad_pkg::MVAD_PG_2K: ofs_width = 4'(mvad_pkg::OFS_W_2K);
            mvad_pkg::MVAD_PG_4K: ofs_width = 4'(mvad_pkg::OFS_W_4K);
            default: ofs_width = 4'(mvad_pkg::OFS_W_8K);
        endcase
    endfunction : ofs_width

    // Two-stage synchronisers on all pin inputs except clock and reset.
    always_ff @(posedge MCLK_I) begin
        pgsz_s1 <= PAGE_SIZE_SEL_I;
        pgsz_s2 <= pgsz_s1;
        vad_s1 <= VIRTUAL_ADDRESS_FLAG_I;
        vad_s2 <= vad_s1;
        vaddr_s1 <= VADDR_I;
        vaddr_s2 <= vaddr_s1;
        acc_s1 <= ACCESS_KIND_I;
        acc_s2 <= acc_s1;
        lvl_s1 <= EXECUTION_MODE_LINES_I;
        lvl_s2 <= lvl_s1;
        perm_s1 <= SEGMENT_PERM_I;
        perm_s2 <= perm_s1;
    end

    // Latch one page size while idle so a change never splits an access.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            pgsz <= mvad_pkg::MVAD_PG_8K;
            vad_q <= 1'b0;
        end else begin
            vad_q <= vad_s2;
            if (state == mvad_pkg::MVAD_ST_IDLE) begin
                pgsz <= pgsz_s2;
            end
        end
    end

    mvad_perm_check u_check (
        .perm_word_i(perm_s2),
        .level_i(lvl_s2),
        .access_i(acc_s2),
        .allow_o(allow)
    );

    // Address strobe rising edge starts a check; answer holds until strobe drops.
    always_comb begin
        next_state = state;
        case (state)
            mvad_pkg::MVAD_ST_IDLE: begin
                if (vad_s2 && !vad_q) begin
                    next_state = mvad_pkg::MVAD_ST_CHECK;
                end
            end
            mvad_pkg::MVAD_ST_CHECK: next_state = mvad_pkg::MVAD_ST_ANSWER;
            default: begin
                if (!vad_s2) begin
                    next_state = mvad_pkg::MVAD_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            state <= mvad_pkg::MVAD_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Split the address into its four fields for the active page size.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            SECTION_ID_FIELD_O <= 2'h0;
            SEGMENT_SELECT_FIELD_O <= 13'h0000;
            PAGE_SELECT_FIELD_O <= 6'h00;
            PAGE_BYTE_OFFSET_FIELD_O <= 13'h0000;
            DECODE_VALID_O <= 1'b0;
        end else begin
            DECODE_VALID_O <= 1'b0;
            if (state == mvad_pkg::MVAD_ST_CHECK) begin
                SECTION_ID_FIELD_O <= vaddr_s2[mvad_pkg::SECT_LSB +: mvad_pkg::SECT_W];
                SEGMENT_SELECT_FIELD_O <= vaddr_s2[mvad_pkg::SEG_LSB +: mvad_pkg::SEG_W];
                // Page field is bits 16 down to the offset width; at most 64 pages.
                PAGE_SELECT_FIELD_O <= 6'(vaddr_s2[16:0] >> ofs_width(pgsz));
                PAGE_BYTE_OFFSET_FIELD_O <= vaddr_s2[12:0] & 13'((17'h00001 << ofs_width(pgsz)) - 17'h00001);
                DECODE_VALID_O <= 1'b1;
            end
        end
    end

    // Open-drain fault and ready: driven low when asserted, released otherwise.
    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            TRANSLATION_FAULT_OUT_O <= 1'b0;
            TRANSLATION_FAULT_OE_O <= 1'b0;
            SYNC_READY_OUT_O <= 1'b0;
            SYNC_READY_OE_O <= 1'b0;
        end else if (state == mvad_pkg::MVAD_ST_CHECK) begin
            TRANSLATION_FAULT_OE_O <= !allow;
            SYNC_READY_OE_O <= allow;
        end else if (next_state == mvad_pkg::MVAD_ST_IDLE) begin
            TRANSLATION_FAULT_OE_O <= 1'b0;
            SYNC_READY_OE_O <= 1'b0;
        end
    end
endmodule : mvad_decode

// ==== hdl/mvad_perm_check.sv ====
`timescale 1ns/1ps
// Combinational permission check for one access.
module mvad_perm_check (
    input wire logic [7:0] perm_word_i,
    input wire logic [1:0] level_i,
    input wire logic [1:0] access_i,
    output logic allow_o
);
    logic [1:0] perm;

    // Select the two permission bits of the current level; level 0 sits in the top pair.
    always_comb begin
        perm = perm_word_i[7 - 2 * level_i -: 2];
        case (perm)
            mvad_pkg::MVAD_PERM_NONE: allow_o = 1'b0;
            mvad_pkg::MVAD_PERM_EXEC: allow_o = (access_i == mvad_pkg::MVAD_ACC_FETCH);
            mvad_pkg::MVAD_PERM_RDEX: allow_o = (access_i != mvad_pkg::MVAD_ACC_WRITE);
            default: allow_o = 1'b1;
        endcase
    end
endmodule : mvad_perm_check

// ==== hdl/mvad_pkg.sv ====
// Contract
// - The virtual space is four sections of up to 8K segments each, and every segment is paged.
// - With the smallest page size a segment holds at most sixty-four pages of 2 Kbyte.
// - Each segment carries one of four permission types for every execution level on its own.
// - Each virtual address splits into section, segment, page and byte-offset fields.
// - For 8K pages the section is bits 31:30, segment 29:17, page 16:13 and offset 12:0.
// - The 2K, 4K and 8K page sizes each have a layout, and the page/offset boundary moves with the size.
// - Fault, ready, acknowledge, size, direction and reset lines wire straight to the processor; the decoder has only reset plus open-drain fault and ready.
// - Only one page size is active at a time, chosen by a configuration field.
// - Each level's permission is two bits: 00 none, 01 execute, 10 read/execute, 11 read/write/execute.
// - The requested access is checked against the current level's permission and a fault is raised if refused.
package mvad_pkg;
    localparam int ADDR_W = 32;
    localparam int SECT_W = 2;
    localparam int SEG_W = 13;
    localparam int PAGE_MAX_W = 6;
    localparam int OFS_MAX_W = 13;
    localparam int SECT_LSB = 30;
    localparam int SEG_LSB = 17;
    localparam int OFS_W_2K = 11;
    localparam int OFS_W_4K = 12;
    localparam int OFS_W_8K = 13;
    localparam int SEGS_PER_SECTION = 8192;
    localparam int PAGES_PER_SEG_2K = 64;

    // Page size selection codes.
    typedef enum logic [1:0] {
        MVAD_PG_2K = 2'h0,
        MVAD_PG_4K = 2'h1,
        MVAD_PG_8K = 2'h3
    } mvad_pgsz_t;

    // Per-level permission codes.
    typedef enum logic [1:0] {
        MVAD_PERM_NONE = 2'h0,
        MVAD_PERM_EXEC = 2'h1,
        MVAD_PERM_RDEX = 2'h2,
        MVAD_PERM_RWEX = 2'h3
    } mvad_perm_t;

    // Access kinds requested by the processor.
    typedef enum logic [1:0] {
        MVAD_ACC_FETCH = 2'h0,
        MVAD_ACC_READ = 2'h1,
        MVAD_ACC_WRITE = 2'h3
    } mvad_acc_t;

    // Access check states.
    typedef enum logic [1:0] {
        MVAD_ST_IDLE = 2'h0,
        MVAD_ST_CHECK = 2'h1,
        MVAD_ST_ANSWER = 2'h3
    } mvad_state_t;
endpackage : mvad_pkg
